// *** hw/tsg_pkg.sv ***
// constants, register map and helpers of the stereo tone generator
// assumes a single 200 MHz core clock and byte-wide register access
package tsg_pkg;

	// register offsets, byte addressed
	localparam logic [7:0] TSG_LEFT_VOL_EN_ADDR = 8'h47; // enable and left volume
	localparam logic [7:0] TSG_RIGHT_VOL_LINK_ADDR = 8'h48; // right volume and link mode
	localparam logic [7:0] TSG_LEN_HIGH_ADDR = 8'h49; // duration bits 23..16
	localparam logic [7:0] TSG_LEN_MID_ADDR = 8'h4a; // duration bits 15..8
	localparam logic [7:0] TSG_LEN_LOW_ADDR = 8'h4b; // duration bits 7..0
	localparam logic [7:0] TSG_SIN_HIGH_ADDR = 8'h4c; // sine coefficient high byte
	localparam logic [7:0] TSG_SIN_LOW_ADDR = 8'h4d; // sine coefficient low byte
	localparam logic [7:0] TSG_COS_HIGH_ADDR = 8'h4e; // cosine coefficient high byte
	localparam logic [7:0] TSG_COS_LOW_ADDR = 8'h4f; // cosine coefficient low byte

	// field positions
	localparam int TSG_EN_BIT = 7; // enable bit in left register
	localparam int TSG_LINK_HI = 7; // link field top bit
	localparam int TSG_LINK_LO = 6; // link field bottom bit
	localparam int TSG_VOL_HI = 5; // volume field top bit

	// reset values
	localparam logic [7:0] TSG_LEFT_RST = 8'h00;
	localparam logic [7:0] TSG_RIGHT_RST = 8'h00;
	localparam logic [7:0] TSG_LEN_HIGH_RST = 8'h00;
	localparam logic [7:0] TSG_LEN_MID_RST = 8'h00;
	localparam logic [7:0] TSG_LEN_LOW_RST = 8'hee;
	localparam logic [7:0] TSG_SIN_HIGH_RST = 8'h00; // no defined value, plain default
	localparam logic [7:0] TSG_SIN_LOW_RST = 8'hd8;
	localparam logic [7:0] TSG_COS_HIGH_RST = 8'h7e;
	localparam logic [7:0] TSG_COS_LOW_RST = 8'he3;
	localparam logic [7:0] TSG_UNMAPPED_DATA = 8'h00; // answer for unknown offsets

	// link modes
	typedef enum logic [1:0] {
		TSG_LINK_INDEP = 2'b00,
		TSG_LINK_LEFT_FROM_RIGHT = 2'b01,
		TSG_LINK_RIGHT_FROM_LEFT = 2'b10,
		TSG_LINK_INDEP_ALT = 2'b11
	} tsg_link_type;

	// playback processing mode in which the tone exists
	localparam logic [4:0] TSG_TONE_CAPABLE_PLAYBACK_MODE = 5'h19;

	// volume: code steps 1 dB, 6 dB per halving, mantissa over one 6 dB span
	localparam logic [5:0] TSG_DB_PER_OCTAVE = 6'h06;
	localparam int TSG_FRAC_BITS = 15; // q1.15 arithmetic
	localparam int TSG_OSC_SHIFT = 14; // q1.15 times two
	localparam logic [15:0] TSG_GAIN_MANT [6] = '{16'ha124, 16'h8f9e, 16'h8000, 16'h7215, 16'h65ad, 16'h5a9e};

	// saturation bounds
	localparam logic signed [15:0] TSG_SAMPLE_MAX = 16'sh7fff;
	localparam logic signed [15:0] TSG_SAMPLE_MIN = -16'sh8000;

	// clamp a wide signed value onto 16 bits
	function automatic logic signed [15:0] tsg_sat16(input logic signed [33:0] v);
		logic signed [15:0] r;
		r = v[15:0];
		if (v > 34'(TSG_SAMPLE_MAX)) begin
			r = TSG_SAMPLE_MAX;
		end else if (v < 34'(TSG_SAMPLE_MIN)) begin
			r = TSG_SAMPLE_MIN;
		end
		return r;
	endfunction : tsg_sat16

endpackage : tsg_pkg

// *** hw/tsg_chan_if.sv ***
// one channel of samples between the generator core and its volume scaler
// assumes both ends share the core clock
interface tsg_chan_if;
	logic signed [15:0] sample; // raw oscillator sample
	logic in_valid; // sample present this cycle
	logic [5:0] vol; // effective volume code
	logic signed [15:0] scaled; // attenuated sample
	logic out_valid; // scaled sample present

	// generator side
	modport core (output sample, output in_valid, output vol, input scaled, input out_valid);
	// scaler side
	modport scaler (input sample, input in_valid, input vol, output scaled, output out_valid);
endinterface : tsg_chan_if

// *** hw/tsg_vol_scaler.sv ***
// volume scaler of one channel: 1 dB steps from +2 dB down to -61 dB
// assumes one sample per in_valid pulse; result comes one cycle later from a register
module tsg_vol_scaler
	import tsg_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	tsg_chan_if.scaler ch
);

	logic [5:0] vol_shift; // whole halvings
	logic [5:0] vol_frac; // remaining dB within one halving
	logic signed [32:0] prod; // sample times mantissa
	logic signed [32:0] scaled_wide; // product after scaling back
	logic signed [15:0] out_sample; // registered result
	logic out_vld; // registered valid

	// split the code into halvings and a fine step
	always_comb begin
		vol_shift = ch.vol / TSG_DB_PER_OCTAVE;
		vol_frac = ch.vol % TSG_DB_PER_OCTAVE;
		prod = ch.sample * $signed({1'b0, TSG_GAIN_MANT[vol_frac[2:0]]});
		scaled_wide = (prod >>> TSG_FRAC_BITS) >>> vol_shift;
	end

	// registered output, saturated against the +2 dB overshoot
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			out_sample <= '0;
			out_vld <= 1'b0;
		end else begin
			out_vld <= ch.in_valid;
			if (ch.in_valid) begin
				out_sample <= tsg_sat16({scaled_wide[32], scaled_wide});
			end
		end
	end

	assign ch.scaled = out_sample;
	assign ch.out_valid = out_vld;

	// code two is unity gain
	a_vol_unity_gain: assert property (@(posedge core_clk_i) disable iff (rst_i)
		ch.in_valid && ch.vol == 6'h02 |=> ch.out_valid && ch.scaled == $past(ch.sample))
		else $error("unity volume code changed the sample");

	// bottom code is at least 60 dB down
	a_vol_floor: assert property (@(posedge core_clk_i) disable iff (rst_i)
		ch.in_valid && ch.vol == 6'h3f |=> ch.scaled <= 16'sh0040 && ch.scaled >= -16'sh0040)
		else $error("lowest volume code not attenuated enough");

endmodule : tsg_vol_scaler

// *** hw/tsg_stereo_tone.sv ***
// stereo sine tone generator feeding the playback processing path
// assumes byte register writes/reads on a simple strobed port and a word clock strobe per sample
// Overview of operation
// - link field couples or separates channel volumes
// - right volume: 1 dB steps, +2 to -61 dB
// - tone only in the tone-capable playback mode
// - duration is 24-bit sample count, three bytes
// - duration resets to 0x0000ee
// - 16-bit sine coefficient, software loads sin(angle)
// - 16-bit cosine coefficient, resets to 0x7ee3
// - sine low byte resets to 0xd8
// - enable starts tone, self-clears after duration
// - left volume uses the same encoding
module tsg_stereo_tone
	import tsg_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic [4:0] proc_mode_i,
	input wire logic word_clk_stb_i,
	output logic signed [15:0] tone_left_o,
	output logic signed [15:0] tone_right_o,
	output logic tone_valid_o,
	output logic tone_active_o
);
	import tsg_pkg::*;

	// register contents
	logic tone_en; // generation running
	logic [5:0] vol_left; // left volume code
	logic [5:0] vol_right; // right volume code
	tsg_link_type link_mode; // volume coupling
	logic [23:0] tone_len; // duration in samples
	logic [15:0] sin_coef; // sine of the step angle
	logic [15:0] cos_coef; // cosine of the step angle
	logic [7:0] rdata; // registered read answer

	// generator state
	logic [23:0] sample_cnt; // samples already produced
	logic signed [15:0] osc_cur; // latest oscillator value
	logic signed [15:0] osc_prev; // value before it
	logic signed [15:0] raw_sample; // sample handed to the scalers
	logic raw_valid; // one-cycle sample pulse
	logic start_pulse; // software just set the enable bit
	logic mode_ok; // playback path can carry the tone
	logic step; // advance the oscillator this cycle
	logic last_sample; // this step ends the tone

	// oscillator arithmetic
	logic signed [31:0] osc_prod; // cos times current value
	logic signed [33:0] osc_sum; // two cos y1 minus y2
	logic signed [15:0] next_osc; // clamped next value

	// effective volumes after linking
	logic [5:0] eff_left;
	logic [5:0] eff_right;

	tsg_chan_if chan[2] ();

	// write decode
	logic wr_left;
	assign wr_left = reg_wr_i && reg_addr_i == TSG_LEFT_VOL_EN_ADDR;
	assign start_pulse = wr_left && reg_wdata_i[TSG_EN_BIT];

	// playback mode gate
	assign mode_ok = proc_mode_i == TSG_TONE_CAPABLE_PLAYBACK_MODE;
	assign step = tone_en && mode_ok && word_clk_stb_i && !start_pulse;
	assign last_sample = sample_cnt + 24'h000001 >= tone_len;

	// left volume and enable; hardware clear on the last sample
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			tone_en <= TSG_LEFT_RST[TSG_EN_BIT];
			vol_left <= TSG_LEFT_RST[TSG_VOL_HI:0];
		end else begin
			if (wr_left) begin
				// software write; a set restarts the tone
				tone_en <= reg_wdata_i[TSG_EN_BIT];
				vol_left <= reg_wdata_i[TSG_VOL_HI:0];
			end else if (step && last_sample) begin
				// duration elapsed
				tone_en <= 1'b0;
			end
		end
	end

	// right volume and link field
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			link_mode <= tsg_link_type'(TSG_RIGHT_RST[TSG_LINK_HI:TSG_LINK_LO]);
			vol_right <= TSG_RIGHT_RST[TSG_VOL_HI:0];
		end else if (reg_wr_i && reg_addr_i == TSG_RIGHT_VOL_LINK_ADDR) begin
			link_mode <= tsg_link_type'(reg_wdata_i[TSG_LINK_HI:TSG_LINK_LO]);
			vol_right <= reg_wdata_i[TSG_VOL_HI:0];
		end
	end

	// duration bytes
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			tone_len <= {TSG_LEN_HIGH_RST, TSG_LEN_MID_RST, TSG_LEN_LOW_RST};
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				TSG_LEN_HIGH_ADDR: begin
					tone_len[23:16] <= reg_wdata_i;
				end
				TSG_LEN_MID_ADDR: begin
					tone_len[15:8] <= reg_wdata_i;
				end
				TSG_LEN_LOW_ADDR: begin
					tone_len[7:0] <= reg_wdata_i;
				end
				default: begin
					// other offsets leave the duration alone
				end
			endcase
		end
	end

	// coefficient bytes
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			sin_coef <= {TSG_SIN_HIGH_RST, TSG_SIN_LOW_RST};
			cos_coef <= {TSG_COS_HIGH_RST, TSG_COS_LOW_RST};
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				TSG_SIN_HIGH_ADDR: begin
					sin_coef[15:8] <= reg_wdata_i;
				end
				TSG_SIN_LOW_ADDR: begin
					sin_coef[7:0] <= reg_wdata_i;
				end
				TSG_COS_HIGH_ADDR: begin
					cos_coef[15:8] <= reg_wdata_i;
				end
				TSG_COS_LOW_ADDR: begin
					cos_coef[7:0] <= reg_wdata_i;
				end
				default: begin
					// other offsets leave the coefficients alone
				end
			endcase
		end
	end

	// read answer, one cycle after the read strobe, held otherwise
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rdata <= TSG_UNMAPPED_DATA;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				TSG_LEFT_VOL_EN_ADDR: begin
					// live enable shows when the tone has finished
					rdata <= {tone_en, 1'b0, vol_left};
				end
				TSG_RIGHT_VOL_LINK_ADDR: begin
					rdata <= {link_mode, vol_right};
				end
				TSG_LEN_HIGH_ADDR: begin
					rdata <= tone_len[23:16];
				end
				TSG_LEN_MID_ADDR: begin
					rdata <= tone_len[15:8];
				end
				TSG_LEN_LOW_ADDR: begin
					rdata <= tone_len[7:0];
				end
				TSG_SIN_HIGH_ADDR: begin
					rdata <= sin_coef[15:8];
				end
				TSG_SIN_LOW_ADDR: begin
					rdata <= sin_coef[7:0];
				end
				TSG_COS_HIGH_ADDR: begin
					rdata <= cos_coef[15:8];
				end
				TSG_COS_LOW_ADDR: begin
					rdata <= cos_coef[7:0];
				end
				default: begin
					rdata <= TSG_UNMAPPED_DATA;
				end
			endcase
		end
	end

	assign reg_rdata_o = rdata;

	// recursion y[n] = 2 cos y[n-1] - y[n-2]
	always_comb begin
		osc_prod = $signed(cos_coef) * osc_cur;
		// both operands signed, so the shift keeps the sign of a negative product
		osc_sum = ($signed({{2{osc_prod[31]}}, osc_prod}) >>> TSG_OSC_SHIFT) - $signed({{18{osc_prev[15]}}, osc_prev});
		next_osc = tsg_sat16(osc_sum);
	end

	// oscillator state and sample counter
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			osc_cur <= '0;
			osc_prev <= '0;
			sample_cnt <= '0;
		end else if (start_pulse) begin
			// seed: first sample is sin of one step, previous is zero
			osc_cur <= $signed(sin_coef);
			osc_prev <= '0;
			sample_cnt <= '0;
		end else if (step) begin
			osc_prev <= osc_cur;
			osc_cur <= next_osc;
			sample_cnt <= sample_cnt + 24'h000001;
		end
	end

	// raw sample pulse towards both scalers
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			raw_sample <= '0;
			raw_valid <= 1'b0;
		end else begin
			raw_valid <= step;
			if (step) begin
				raw_sample <= osc_cur;
			end
		end
	end

	// volume linking
	always_comb begin
		eff_left = vol_left;
		eff_right = vol_right;
		unique case (link_mode)
			TSG_LINK_LEFT_FROM_RIGHT: begin
				eff_left = vol_right;
			end
			TSG_LINK_RIGHT_FROM_LEFT: begin
				eff_right = vol_left;
			end
			TSG_LINK_INDEP, TSG_LINK_INDEP_ALT: begin
				// each side keeps its own code
			end
		endcase
	end

	// one scaler per channel; index 0 is left
	for (genvar i = 0; i < 2; i++) begin : g_chan
		assign chan[i].sample = raw_sample;
		assign chan[i].in_valid = raw_valid;
		assign chan[i].vol = (i == 0) ? eff_left : eff_right;
		tsg_vol_scaler u_scaler (
			.core_clk_i(core_clk_i),
			.rst_i(rst_i),
			.ch(chan[i])
		);
	end

	// outputs
	assign tone_left_o = chan[0].scaled;
	assign tone_right_o = chan[1].scaled;
	assign tone_valid_o = chan[0].out_valid;
	assign tone_active_o = tone_en;

	// linked left follows right
	a_link_left_right: assert property (@(posedge core_clk_i) disable iff (rst_i)
		link_mode == TSG_LINK_LEFT_FROM_RIGHT |-> eff_left == vol_right && eff_right == vol_right)
		else $error("left volume not taken from right");

	// linked right follows left
	a_link_right_left: assert property (@(posedge core_clk_i) disable iff (rst_i)
		link_mode == TSG_LINK_RIGHT_FROM_LEFT |-> eff_right == vol_left && eff_left == vol_left)
		else $error("right volume not taken from left");

	// no tone outside the capable mode
	a_mode_gate_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!mode_ok && word_clk_stb_i |=> ##1 !tone_valid_o)
		else $error("tone produced outside the capable mode");

	// reset values of duration and coefficients
	a_reset_values: assert property (@(posedge core_clk_i)
		$fell(rst_i) |-> tone_len == 24'h0000ee && cos_coef == 16'h7ee3 && sin_coef[7:0] == 8'hd8)
		else $error("register reset value wrong");

	// start seeds the oscillator from the sine coefficient
	a_sine_seed: assert property (@(posedge core_clk_i) disable iff (rst_i)
		start_pulse |=> osc_cur == $past(sin_coef) && sample_cnt == 24'h000000 && tone_en)
		else $error("oscillator not seeded on start");

	// enable drops right after the last sample
	a_self_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
		step && last_sample |=> !tone_en ##1 tone_valid_o)
		else $error("enable not cleared after the duration");

	// counter advances by one per sample
	a_count_step: assert property (@(posedge core_clk_i) disable iff (rst_i)
		step && !last_sample |=> sample_cnt == $past(sample_cnt) + 24'h000001 && tone_en)
		else $error("sample counter did not advance");

	// every output sample comes two cycles after a word clock
	a_sample_rate: assert property (@(posedge core_clk_i) disable iff (rst_i)
		tone_valid_o |-> $past(word_clk_stb_i, 2) && $past(mode_ok, 2))
		else $error("sample without a word clock");

endmodule : tsg_stereo_tone

// *** tb/tsg_play_model.sv ***
// playback path model: word clock strobes and the processing mode
// assumes the core clock; strobes stop while run_i is low
module tsg_play_model (
	input wire logic core_clk_i,
	input wire logic run_i,
	input wire logic [4:0] mode_i,
	output logic word_clk_stb_o,
	output logic [4:0] proc_mode_o
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [2:0] phase = 3'h0; // word clock divider
	initial begin
		word_clk_stb_o = 1'b0;
		proc_mode_o = 5'h00;
	end

	// one strobe in eight cycles, changed just after the edge
	always @(posedge core_clk_i) begin
		#1;
		phase <= phase + 3'h1;
		word_clk_stb_o <= run_i && (phase == 3'h7);
		proc_mode_o <= mode_i;
	end
endmodule : tsg_play_model

// *** tb/tb_top.sv ***
// register and tone stream tests of the stereo tone generator
// assumes the design package; the playback path is the partner model
module tb_top
	import tsg_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic core_clk = 1'b0; // 200 MHz core clock
	logic rst = 1'b1; // synchronous reset
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic run = 1'b0; // word clock running
	logic [4:0] mode = TSG_TONE_CAPABLE_PLAYBACK_MODE;
	logic stb;
	logic [4:0] pmode;
	logic signed [15:0] tone_left;
	logic signed [15:0] tone_right;
	logic tone_valid;
	logic tone_active;
	logic [15:0] sin_coef = 16'h00d8; // coefficients as programmed
	logic [15:0] cos_coef = 16'h7ee3;
	logic [7:0] d; // read result
	int num_errors = 0;
	int checks_done = 0;

	always #2.5 core_clk = ~core_clk;

	tsg_play_model partner (.core_clk_i(core_clk), .run_i(run), .mode_i(mode),
		.word_clk_stb_o(stb), .proc_mode_o(pmode));

	tsg_stereo_tone dut (.core_clk_i(core_clk), .rst_i(rst), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
		.proc_mode_i(pmode), .word_clk_stb_i(stb), .tone_left_o(tone_left),
		.tone_right_o(tone_right), .tone_valid_o(tone_valid), .tone_active_o(tone_active));

	// compare and count
	task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
		checks_done++;
		if (seen !== want) begin
			num_errors++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, want);
		end
	endtask : check

	// verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results

	// one-cycle write strobe
	task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge core_clk);
		#1;
		reg_wr = 1'b0;
	endtask : reg_write

	// one-cycle read strobe, data one edge later
	task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge core_clk);
		#1;
		reg_rd = 1'b0;
		v = reg_rdata;
	endtask : reg_read

	// clamp onto 16 bits
	function automatic logic signed [15:0] sat(input logic signed [33:0] v);
		if (v > 34'sd32767) begin
			return 16'sh7fff;
		end
		if (v < -34'sd32768) begin
			return 16'sh8000;
		end
		return v[15:0];
	endfunction : sat

	// attenuation of one volume code
	function automatic logic signed [15:0] scale(input logic signed [15:0] y, input logic [5:0] v);
		logic signed [33:0] p;
		p = y * $signed({1'b0, TSG_GAIN_MANT[v % 6]});
		return sat((p >>> 15) >>> (v / 6));
	endfunction : scale

	// program and play one tone, optionally stalled in a wrong mode first
	task automatic run_tone(input logic [1:0] link, input logic [5:0] lv, input logic [5:0] rv,
			input logic [23:0] n, input bit stall);
		logic signed [15:0] y1, y2, y;
		logic signed [33:0] p;
		logic [5:0] el, er;
		int k, t;
		el = (link == 2'b01) ? rv : lv;
		er = (link == 2'b10) ? lv : rv;
		y1 = sin_coef;
		y2 = 16'sh0000;
		k = 0;
		reg_write(TSG_LEN_HIGH_ADDR, n[23:16]);
		reg_write(TSG_LEN_MID_ADDR, n[15:8]);
		reg_write(TSG_LEN_LOW_ADDR, n[7:0]);
		reg_write(TSG_RIGHT_VOL_LINK_ADDR, {link, rv});
		if (stall) begin
			mode = 5'h00;
		end
		reg_write(TSG_LEFT_VOL_EN_ADDR, {2'b10, lv});
		if (stall) begin
			t = 0;
			repeat (40) begin
				@(posedge core_clk);
				#1;
				t += int'(tone_valid);
			end
			check(16'(t), 16'h0000, "samples in wrong mode");
			check({15'h0, tone_active}, 16'h0001, "enable held");
			mode = TSG_TONE_CAPABLE_PLAYBACK_MODE;
		end
		t = 0;
		while (k < int'(n) && t < 8 * int'(n) + 64) begin
			@(posedge core_clk);
			#1;
			t++;
			if (tone_valid === 1'b1) begin
				check(tone_left, scale(y1, el), "left sample");
				check(tone_right, scale(y1, er), "right sample");
				p = $signed(cos_coef) * y1;
				y = sat((p >>> 14) - y2);
				y2 = y1;
				y1 = y;
				k++;
			end
		end
		if (k < int'(n)) begin
			num_errors++;
			$display("wrong value at %0t: tone stream stopped early", $time);
			results();
		end
		repeat (4) @(posedge core_clk);
		#1;
		check({15'h0, tone_active}, 16'h0000, "self clear");
		t = 0;
		repeat (30) begin
			@(posedge core_clk);
			#1;
			t += int'(tone_valid);
		end
		check(16'(t), 16'h0000, "samples past duration");
		reg_read(TSG_LEFT_VOL_EN_ADDR, d);
		check(d, {2'b00, lv}, "enable bit cleared");
		$display("tone test done: link %b samples %0d", link, n);
	endtask : run_tone

	logic [7:0] rst_tab [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hee, 8'h00, 8'hd8, 8'h7e, 8'he3};

	// main sequence
	initial begin
		repeat (6) @(posedge core_clk);
		#1;
		rst = 1'b0;
		run = 1'b1;
		for (int i = 0; i < 9; i++) begin
			reg_read(8'h47 + 8'(i), d);
			check(d, rst_tab[i], "reset value");
		end
		$display("reset value test done");
		run_tone(2'b00, 6'd2, 6'd63, 24'd3, 1'b0);
		for (int i = 1; i < 9; i++) begin
			reg_write(8'h47 + 8'(i), 8'ha5 ^ 8'(i));
		end
		for (int i = 1; i < 9; i++) begin
			reg_read(8'h47 + 8'(i), d);
			check(d, 8'ha5 ^ 8'(i), "read back");
		end
		reg_write(TSG_LEFT_VOL_EN_ADDR, 8'h7f);
		reg_read(TSG_LEFT_VOL_EN_ADDR, d);
		check(d, 8'h3f, "reserved bit");
		reg_write(8'h50, 8'hff);
		reg_read(8'h50, d);
		check(d, 8'h00, "unmapped offset");
		$display("register access test done");
		sin_coef = 16'h18f9;
		cos_coef = 16'h7d8a;
		reg_write(TSG_SIN_HIGH_ADDR, sin_coef[15:8]);
		reg_write(TSG_SIN_LOW_ADDR, sin_coef[7:0]);
		reg_write(TSG_COS_HIGH_ADDR, cos_coef[15:8]);
		reg_write(TSG_COS_LOW_ADDR, cos_coef[7:0]);
		run_tone(2'b01, 6'd2, 6'd8, 24'd5, 1'b0);
		run_tone(2'b10, 6'd0, 6'd8, 24'd4, 1'b0);
		run_tone(2'b11, 6'd5, 6'd2, 24'd2, 1'b1);
		run_tone(2'b00, 6'd0, 6'd12, 24'h000100, 1'b0);
		results();
	end
endmodule : tb_top
